// [logic/interrupt_source_flags_params.svh]
// Register indices, field positions, reset values and timing counts for the interrupt flag block
`ifndef INTERRUPT_SOURCE_FLAGS_PARAMS_SVH
`define INTERRUPT_SOURCE_FLAGS_PARAMS_SVH

// Register indices; byte address is four times the index
`define IDX_PEND_6_1      18'h0_fe04
`define IDX_PEND_14_7     18'h0_fe05
`define IDX_PEND_20_15    18'h0_fe06
`define IDX_SERIAL_CTRL   18'h0_fe08
`define IDX_SERIAL_FLAGS  18'h0_fe09
`define IDX_CONV_CTRL     18'h0_fe0a
`define IDX_TB_CTRL       18'h0_fe0b
`define IDX_NET_ENABLES   18'h0_fe0c
`define IDX_NET_FLAGS     18'h0_fe0d
`define IDX_KBD_CTRL      18'h0_fe0e

// Serial control fields
`define SER_QUIET_EN      0
`define SER_OVERRUN_EN    1
`define SER_NOISE_EN      2
`define SER_FRAMING_EN    3
`define SER_PARITY_EN     4
`define SER_LONG_CHAR     5
// Serial flag fields
`define SER_QUIET_F       0
`define SER_OVERRUN_F     1
`define SER_NOISE_F       2
`define SER_FRAMING_F     3
`define SER_PARITY_F      4

// Timebase control fields
`define TB_RATE_LSB       0
`define TB_IRQ_EN         3
`define TB_ACK            4
`define TB_FLAG           5

// Network enable and flag fields (bits 2:0 are the transmit buffers)
`define NET_RXF           3
`define NET_WAKE          4
`define NET_OVR           5
`define NET_RWRN          6
`define NET_TWRN          7
`define NET_RPASS         8
`define NET_TPASS         9
`define NET_BOFF          10

// Counts and limits
`define QUIET_BITS_SHORT  4'h0_00a
`define QUIET_BITS_LONG   4'h0_00b
`define NET_WARN_LIMIT    9'h0_060
`define NET_PASSIVE_LIMIT 9'h0_07f
`define NET_BUSOFF_LIMIT  9'h0_0ff
`define TB_BASE_BITS      5'h0_03
`define RESET_BYTE        8'h0_0

`endif

// [logic/interrupt_source_flags_pkg.sv]
// Types shared by the interrupt flag block
package interrupt_source_flags_pkg;

    // Pending request vector, bit n is request n
    typedef logic [20:1] req_vec_t;

    // Bus answer sequencing
    typedef enum logic [0:0] {
        BUS_IDLE,
        BUS_ANSWER
    } bus_state_e;

endpackage : interrupt_source_flags_pkg

// [logic/interrupt_source_flags.sv]
// Interrupt source flag gathering, masking and pending status registers behind APB
//
// Notes on behaviour
// - Ten or eleven quiet bits set line-quiet flag
// - New character before read sets overrun flag
// - Noise on any sampled bit sets flag
// - Low stop bit sets framing error flag
// - Parity mismatch sets parity error flag
// - Enabled serial errors share one request
// - Any low keyboard pin latches request
// - Converter enable: request, no complete bit
// - Timebase rollover flag at selected rate, gated
// - Per-buffer transmit empty flags, gated requests
// - Good message received sets receive-full flag
// - Bus activity in sleep sets wake-up
// - Both buffers full plus reception: overrun
// - Receive errors reaching 96 set warning
// - Transmit errors reaching 96 set warning
// - Receive errors above 127 set passive
// - Transmit errors above 127 set passive
// - Transmit errors above 255 set bus-off
// - Request bits one to twenty mapped
// - Status bit shows request; first register's low two bits zero
// - Third register holds flags twenty to fifteen
`timescale 1ns/1ps
`default_nettype none
`include "interrupt_source_flags_params.svh"

module interrupt_source_flags #(
    parameter int ADDR_W   = 20,
    parameter int TB_WIDTH = 18
) (
    // Clock and reset
    input  wire logic                              mclk,
    input  wire logic                              reset_n,
    // APB slave
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire logic [ADDR_W-1:0]                 paddr,
    input  wire logic [31:0]                       pwdata,
    output logic      [31:0]                       prdata,
    output logic                                   pready,
    output logic                                   pslverr,
    // Requests from sources outside this block
    input  wire logic                              ext_pin_req,
    input  wire logic                              lock_change_req,
    input  wire logic [2:0]                        timer1_req,
    input  wire logic [2:0]                        timer2_req,
    input  wire logic [1:0]                        spi_req,
    input  wire logic                              serial_rx_full_req,
    input  wire logic                              serial_tx_req,
    // Serial receiver events
    input  wire logic                              rx_pin,
    input  wire logic                              rx_bit_strobe,
    input  wire logic                              rx_char_done,
    input  wire logic                              rx_data_read,
    input  wire logic                              rx_noise_seen,
    input  wire logic                              rx_stop_strobe,
    input  wire logic                              rx_parity_strobe,
    input  wire logic                              rx_parity_bit,
    input  wire logic                              rx_parity_expect,
    // Keyboard pins
    input  wire logic [7:0]                        keyboard_irq_pins,
    // Converter events
    input  wire logic                              conv_done,
    input  wire logic                              conv_data_read,
    // Network controller state
    input  wire logic [2:0]                        net_tx_buffer_empty,
    input  wire logic                              net_rx_msg_ok,
    input  wire logic                              net_sleep_mode,
    input  wire logic                              net_bus_activity,
    input  wire logic                              net_fg_valid,
    input  wire logic                              net_bg_valid,
    input  wire logic                              net_rx_msg_start,
    input  wire logic [7:0]                        net_rx_err_cnt,
    input  wire logic [8:0]                        net_tx_err_cnt,
    // Toward the processor core
    output interrupt_source_flags_pkg::req_vec_t   irq_req,
    output logic                                   conversion_complete_bit
);
    import interrupt_source_flags_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State
    bus_state_e  bus_q;
    logic [31:0] prdata_q;
    logic        pslverr_q;
    req_vec_t    pend_q;
    logic [5:0]  serial_ctrl_q;
    logic [4:0]  serial_flags_q;
    logic [3:0]  quiet_cnt_q;
    logic        rx_unread_q;
    logic        kbd_latch_q;
    logic        conv_en_q;
    logic        conv_irq_q;
    logic        conversion_complete_bit_q;
    logic [2:0]  tb_rate_q;
    logic        tb_en_q;
    logic        tb_flag_q;
    logic [TB_WIDTH-1:0] tb_cnt_q;
    logic [10:0] net_en_q;
    logic [10:3] net_flags_q;
    logic [8:0]  rx_err_prev_q;
    logic [8:0]  tx_err_prev_q;

    ////////////////////////////////////////////////////////////////////////////
    // APB decode; a write lands only on the edge that completes the access
    wire [ADDR_W-3:0] idx       = paddr[ADDR_W-1:2];
    wire hit_p1       = idx == `IDX_PEND_6_1;
    wire hit_p2       = idx == `IDX_PEND_14_7;
    wire hit_p3       = idx == `IDX_PEND_20_15;
    wire hit_sctrl    = idx == `IDX_SERIAL_CTRL;
    wire hit_sflags   = idx == `IDX_SERIAL_FLAGS;
    wire hit_conv     = idx == `IDX_CONV_CTRL;
    wire hit_tb       = idx == `IDX_TB_CTRL;
    wire hit_nen      = idx == `IDX_NET_ENABLES;
    wire hit_nflags   = idx == `IDX_NET_FLAGS;
    wire hit_kbd      = idx == `IDX_KBD_CTRL;
    wire hit_any      = hit_p1 | hit_p2 | hit_p3 | hit_sctrl | hit_sflags | hit_conv
                        | hit_tb | hit_nen | hit_nflags | hit_kbd;
    wire access_start = psel & penable & (bus_q == BUS_IDLE);
    wire access_done  = psel & penable & (bus_q == BUS_ANSWER);
    wire wr           = access_done & pwrite & ~pslverr_q;

    ////////////////////////////////////////////////////////////////////////////
    // Serial receiver flags; a set on the clearing cycle wins
    wire [3:0] quiet_limit = serial_ctrl_q[`SER_LONG_CHAR] ? `QUIET_BITS_LONG : `QUIET_BITS_SHORT;
    wire quiet_set   = rx_bit_strobe & rx_pin & (quiet_cnt_q == quiet_limit - 4'h0_001);
    wire overrun_set = rx_char_done & rx_unread_q & ~rx_data_read;
    wire framing_set = rx_stop_strobe & ~rx_pin;
    wire parity_set  = rx_parity_strobe & (rx_parity_bit != rx_parity_expect);
    wire [4:0] ser_set = {parity_set, framing_set, rx_noise_seen, overrun_set, quiet_set};
    wire [4:0] ser_clr = (wr & hit_sflags) ? pwdata[4:0] : 5'h0_0;
    wire [4:0] ser_flags_d = (serial_flags_q & ~ser_clr) | ser_set;
    wire serial_err_req = |(serial_flags_q[4:1] & serial_ctrl_q[4:1]);
    wire serial_quiet_req = serial_flags_q[`SER_QUIET_F] & serial_ctrl_q[`SER_QUIET_EN];

    // Consecutive high bits counted up to the limit, cleared by any low bit
    wire [3:0] quiet_cnt_d = ~rx_bit_strobe ? quiet_cnt_q
                           : ~rx_pin ? 4'h0_000
                           : (quiet_cnt_q == quiet_limit) ? quiet_cnt_q
                           : quiet_cnt_q + 4'h0_001;

    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            serial_flags_q <= 5'h0_0;
            quiet_cnt_q    <= 4'h0_000;
            rx_unread_q    <= 1'b0;
        end
        else
        begin
            serial_flags_q <= ser_flags_d;
            quiet_cnt_q    <= quiet_cnt_d;
            rx_unread_q    <= rx_char_done | (rx_unread_q & ~rx_data_read);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Keyboard latch and converter; a fresh completion wins over a data read
    wire kbd_low   = ~&keyboard_irq_pins;
    wire kbd_clr   = wr & hit_kbd & pwdata[0];
    wire conv_irq_d = (conv_done & conv_en_q) | (conv_irq_q & ~conv_data_read);
    wire conversion_complete_bit_d     = (conv_done & ~conv_en_q) | (conversion_complete_bit_q & ~conv_data_read & ~conv_en_q);

    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            kbd_latch_q <= 1'b0;
            conv_irq_q  <= 1'b0;
            conversion_complete_bit_q      <= 1'b0;
        end
        else
        begin
            kbd_latch_q <= kbd_low | (kbd_latch_q & ~kbd_clr);
            conv_irq_q  <= conv_irq_d;
            conversion_complete_bit_q      <= conversion_complete_bit_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Timebase; rollover period is two to the power of three plus twice the rate
    wire [4:0] tb_span  = `TB_BASE_BITS + {1'b0, tb_rate_q, 1'b0};
    wire [TB_WIDTH-1:0] tb_mask = ~({TB_WIDTH{1'b1}} << tb_span);
    wire tb_roll  = (tb_cnt_q & tb_mask) == tb_mask;
    wire tb_ack   = wr & hit_tb & pwdata[`TB_ACK];
    wire tb_req   = tb_flag_q & tb_en_q;

    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            tb_cnt_q  <= '0;
            tb_flag_q <= 1'b0;
        end
        else
        begin
            tb_cnt_q  <= tb_cnt_q + 1'b1;
            tb_flag_q <= tb_roll | (tb_flag_q & ~tb_ack);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Network controller flags; error flags fire on crossing the limit
    wire [8:0] rx_err9   = {1'b0, net_rx_err_cnt};
    wire rwrn_set  = (rx_err9 >= `NET_WARN_LIMIT) & (rx_err_prev_q < `NET_WARN_LIMIT);
    wire twrn_set  = (net_tx_err_cnt >= `NET_WARN_LIMIT) & (tx_err_prev_q < `NET_WARN_LIMIT);
    wire rpass_set = (rx_err9 > `NET_PASSIVE_LIMIT) & (rx_err_prev_q <= `NET_PASSIVE_LIMIT);
    wire tpass_set = (net_tx_err_cnt > `NET_PASSIVE_LIMIT) & (tx_err_prev_q <= `NET_PASSIVE_LIMIT);
    wire boff_set  = (net_tx_err_cnt > `NET_BUSOFF_LIMIT) & (tx_err_prev_q <= `NET_BUSOFF_LIMIT);
    wire ovr_set   = net_fg_valid & net_bg_valid & net_rx_msg_start;
    wire wake_set  = net_sleep_mode & net_bus_activity;
    wire [10:3] net_set = {boff_set, tpass_set, rpass_set, twrn_set, rwrn_set, ovr_set, wake_set,
                           net_rx_msg_ok};
    wire [10:3] net_clr = (wr & hit_nflags) ? pwdata[10:3] : 8'h0_0;
    wire net_err_req  = |(net_flags_q[10:5] & net_en_q[10:5]);
    wire net_tx_req   = |(net_tx_buffer_empty & net_en_q[2:0]);
    wire net_rx_req   = net_flags_q[`NET_RXF] & net_en_q[`NET_RXF];
    wire net_wake_req = net_flags_q[`NET_WAKE] & net_en_q[`NET_WAKE];

    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            net_flags_q   <= 8'h0_0;
            rx_err_prev_q <= 9'h0_000;
            tx_err_prev_q <= 9'h0_000;
        end
        else
        begin
            net_flags_q   <= (net_flags_q & ~net_clr) | net_set;
            rx_err_prev_q <= rx_err9;
            tx_err_prev_q <= net_tx_err_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Request vector in pending-bit order
    wire [20:1] req_d = {net_tx_req, net_rx_req, net_err_req, net_wake_req,
                         tb_req, conv_irq_q, kbd_latch_q,
                         serial_tx_req, serial_rx_full_req | serial_quiet_req, serial_err_req,
                         spi_req, timer2_req, timer1_req, lock_change_req, ext_pin_req};

    ////////////////////////////////////////////////////////////////////////////
    // Software-written control registers and the pending request register
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            serial_ctrl_q <= 6'h0_0;
            conv_en_q     <= 1'b0;
            tb_rate_q     <= 3'h0;
            tb_en_q       <= 1'b0;
            net_en_q      <= 11'h0_00;
            pend_q        <= '0;
        end
        else
        begin
            pend_q <= req_d;
            if (wr & hit_sctrl)
                serial_ctrl_q <= pwdata[5:0];
            if (wr & hit_conv)
                conv_en_q <= pwdata[0];
            if (wr & hit_tb)
            begin
                tb_rate_q <= pwdata[`TB_RATE_LSB +: 3];
                tb_en_q   <= pwdata[`TB_IRQ_EN];
            end
            if (wr & hit_nen)
                net_en_q <= pwdata[10:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux; status registers ignore writes; the first shows its low two bits as zero, the third its top two
    wire [31:0] rd_p1 = {24'h0_000, pend_q[6:1], 2'b00};
    wire [31:0] rd_p2 = {24'h0_000, pend_q[14:7]};
    wire [31:0] rd_p3 = {24'h0_000, 2'b00, pend_q[20:15]};
    wire [31:0] rd_tb = {26'h0_000, tb_flag_q, 1'b0, tb_en_q, tb_rate_q};
    wire [31:0] rd_nf = {21'h0_0000, net_flags_q, net_tx_buffer_empty};
    wire [31:0] rd_data = hit_p1     ? rd_p1
                        : hit_p2     ? rd_p2
                        : hit_p3     ? rd_p3
                        : hit_sctrl  ? {26'h0_000, serial_ctrl_q}
                        : hit_sflags ? {27'h0_000, serial_flags_q}
                        : hit_conv   ? {30'h0_000, conversion_complete_bit_q, conv_en_q}
                        : hit_tb     ? rd_tb
                        : hit_nen    ? {21'h0_0000, net_en_q}
                        : hit_nflags ? rd_nf
                        : hit_kbd    ? {31'h0_000, kbd_latch_q}
                        : 32'h0_000;

    // Every access takes one wait state, which keeps all answers registered
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            bus_q     <= BUS_IDLE;
            prdata_q  <= 32'h0_000;
            pslverr_q <= 1'b0;
        end
        else if (access_start)
        begin
            bus_q     <= BUS_ANSWER;
            prdata_q  <= pwrite ? 32'h0_000 : rd_data;
            pslverr_q <= ~hit_any;
        end
        else
        begin
            bus_q     <= BUS_IDLE;
            pslverr_q <= 1'b0;
        end
    end

    assign prdata                  = prdata_q;
    assign pready                  = bus_q == BUS_ANSWER;
    assign pslverr                 = pslverr_q;
    assign irq_req                 = pend_q;
    assign conversion_complete_bit = conversion_complete_bit_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_quiet_run;
        rx_bit_strobe && rx_pin && quiet_cnt_q == quiet_limit - 4'h0_001;
    endsequence
    property p_quiet;
        @(posedge mclk) disable iff (!reset_n)
        s_quiet_run |=> serial_flags_q[`SER_QUIET_F];
    endproperty
    a_quiet: assert property (p_quiet) else $error("line-quiet flag not set");

    property p_overrun;
        @(posedge mclk) disable iff (!reset_n)
        rx_char_done ##1 (!rx_data_read && rx_char_done) |=> serial_flags_q[`SER_OVERRUN_F];
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun flag missed");

    property p_framing;
        @(posedge mclk) disable iff (!reset_n)
        rx_stop_strobe && !rx_pin |=> serial_flags_q[`SER_FRAMING_F];
    endproperty
    a_framing: assert property (p_framing) else $error("framing flag missed");

    property p_serial_err;
        @(posedge mclk) disable iff (!reset_n)
        (rx_noise_seen && serial_ctrl_q[`SER_NOISE_EN]) ##1 serial_ctrl_q[`SER_NOISE_EN] |=> pend_q[11];
    endproperty
    a_serial_err: assert property (p_serial_err) else $error("serial error request missing");

    property p_keyboard;
        @(posedge mclk) disable iff (!reset_n)
        !(&keyboard_irq_pins) |=> ##1 pend_q[14];
    endproperty
    a_keyboard: assert property (p_keyboard) else $error("keyboard request not latched");

    property p_conv;
        @(posedge mclk) disable iff (!reset_n)
        conv_en_q |=> !conversion_complete_bit_q;
    endproperty
    a_conv: assert property (p_conv) else $error("complete bit set while interrupts enabled");

    property p_tb_ack;
        @(posedge mclk) disable iff (!reset_n)
        tb_ack && !tb_roll |=> !tb_flag_q;
    endproperty
    a_tb_ack: assert property (p_tb_ack) else $error("timebase acknowledge ignored");

    property p_busoff;
        @(posedge mclk) disable iff (!reset_n)
        $past(net_tx_err_cnt) <= `NET_BUSOFF_LIMIT && net_tx_err_cnt > `NET_BUSOFF_LIMIT
            |=> net_flags_q[`NET_BOFF];
    endproperty
    a_busoff: assert property (p_busoff) else $error("bus-off flag missed");

    property p_status_low;
        @(posedge mclk) disable iff (!reset_n)
        access_start && hit_p1 && !pwrite |=> prdata[1:0] == 2'b00 && prdata[7:2] == $past(pend_q[6:1]);
    endproperty
    a_status_low: assert property (p_status_low) else $error("first status register wrong");

    property p_status3;
        @(posedge mclk) disable iff (!reset_n)
        access_start && hit_p3 && !pwrite |=> prdata[7:6] == 2'b00 && prdata[5:0] == $past(pend_q[20:15]);
    endproperty
    a_status3: assert property (p_status3) else $error("third status register wrong");

    property p_tx_empty;
        @(posedge mclk) disable iff (!reset_n)
        |(net_tx_buffer_empty & net_en_q[2:0]) |=> pend_q[20];
    endproperty
    a_tx_empty: assert property (p_tx_empty) else $error("transmit empty request missing");

endmodule : interrupt_source_flags
`default_nettype wire

// [dv/irq_source_model.sv]
// Peripheral request sources that drive the level request inputs
`timescale 1ns/1ps
`default_nettype none
module irq_source_model (
    // Clock and load strobe
    input  wire logic        mclk,
    input  wire logic        load,
    input  wire logic [11:0] value,
    // Request levels, held until reloaded
    output logic      [11:0] req
);
    // A source holds its request until the next load, so levels never glitch
    always_ff @(posedge mclk)
        if (load)
            req <= value;
endmodule : irq_source_model
`default_nettype wire

// [dv/interrupt_source_flags_tb.sv]
// Self-checking bench for the interrupt flag block
`timescale 1ns/1ps
`default_nettype none
`include "interrupt_source_flags_params.svh"
module interrupt_source_flags_tb;
    import interrupt_source_flags_pkg::*;
    logic        mclk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic        pready, pslverr, e, ccb, rxp = 1, pb = 0, slp = 0, fgv = 0, bgv = 0;
    logic [19:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, v, seed = 32'h0000_0016;
    logic [10:0] p = '0;
    logic [11:0] raw = '0, req;
    logic [7:0]  kbd = 8'hff, rxc = '0;
    logic [8:0]  txc = '0;
    logic [2:0]  txe = '0;
    req_vec_t    irq_req, ev = '0;
    int          err_count = 0, compares = 0, n, lim;
    longint      t0, t1;
    always #25 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////////////////
    irq_source_model irq_source_model_i (.mclk(mclk), .load(1'b1), .value(raw), .req(req));
    interrupt_source_flags interrupt_source_flags_i (.mclk(mclk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_pin_req(req[0]), .lock_change_req(req[1]),
        .timer1_req(req[4:2]), .timer2_req(req[7:5]), .spi_req(req[9:8]),
        .serial_rx_full_req(req[10]), .serial_tx_req(req[11]), .rx_pin(rxp), .rx_bit_strobe(p[0]),
        .rx_char_done(p[1]), .rx_data_read(p[2]), .rx_noise_seen(p[3]), .rx_stop_strobe(p[4]),
        .rx_parity_strobe(p[5]), .rx_parity_bit(pb), .rx_parity_expect(1'b0),
        .keyboard_irq_pins(kbd), .conv_done(p[6]), .conv_data_read(p[7]), .net_tx_buffer_empty(txe),
        .net_rx_msg_ok(p[8]), .net_sleep_mode(slp), .net_bus_activity(p[9]), .net_fg_valid(fgv),
        .net_bg_valid(bgv), .net_rx_msg_start(p[10]), .net_rx_err_cnt(rxc), .net_tx_err_cnt(txc),
        .irq_req(irq_req), .conversion_complete_bit(ccb));
    ////////////////////////////////////////////////////////////////////////////
    // Repeatable xorshift stream
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    // Expected status word from the expected request vector
    function automatic logic [31:0] rmap(input logic [17:0] ix);
        case (ix)
            `IDX_PEND_6_1:  return {24'h0, ev[6:1], 2'b00};
            `IDX_PEND_14_7: return {24'h0, ev[14:7]};
            default:        return {26'h0, ev[20:15]};
        endcase
    endfunction : rmap
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        compares++;
        if (g !== x)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, x, g);
        end
    endtask : chk
    // APB master: holds the request until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [17:0] ix, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1;
        pwrite <= w;
        paddr <= {ix, 2'b00};
        pwdata <= d;
        @(posedge mclk);
        penable <= 1;
        n = 0;
        do @(posedge mclk); while (pready !== 1'b1 && ++n < 20);
        chk("pready", 1, pready);
        v = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    // Request lines and all three status registers against the expectation
    task automatic cmp_all();
        @(posedge mclk);
        @(negedge mclk);
        chk("irq_req", ev, irq_req);
        for (int r = 4; r < 7; r++)
        begin
            apb(0, 18'(18'h0_fe00 + r), 32'h0000_0000);
            chk("status", rmap(18'(18'h0_fe00 + r)), v);
        end
    endtask : cmp_all
    // Holds one event strobe high for c back-to-back cycles, so c events land
    task automatic pulse(input int i, input int c);
        @(posedge mclk);
        p[i] <= 1;
        repeat (c) @(posedge mclk);
        p[i] <= 0;
    endtask : pulse
    // Waits for a timebase request and notes when it was seen
    task automatic tb_rise(output longint t);
        n = 0;
        do @(negedge mclk); while (irq_req[16] !== 1'b1 && ++n < 600);
        t = $time;
    endtask : tb_rise
    task automatic results();
        if (err_count == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (5) @(posedge mclk);
        reset_n <= 1;
        cmp_all();
        repeat (4)
        begin
            v = xs();
            raw <= v[11:0];
            @(posedge mclk);
            ev = {7'h0, raw[11:10], 1'b0, raw[9:0]};
            cmp_all();
        end
        apb(1, `IDX_PEND_6_1, 32'hffff_ffff);
        cmp_all();
        apb(0, 18'h0_fe07, 32'h0000_0000);
        chk("slverr", 1, e);
        raw <= '0;
        ev = '0;
        // Each serial error kind, then a disabled one
        apb(1, `IDX_SERIAL_CTRL, 32'h0000_001f);
        for (int k = 0; k < 5; k++)
        begin
            rxp <= k != 2;
            pb <= 1;
            case (k)
                0: pulse(1, 2);
                1: pulse(3, 1);
                2: pulse(4, 1);
                3: pulse(5, 1);
                default: apb(1, `IDX_SERIAL_CTRL, 32'h0000_0000);
            endcase
            if (k == 4)
                pulse(3, 1);
            ev[11] = k < 4;
            cmp_all();
            apb(1, `IDX_SERIAL_FLAGS, 32'h0000_001f);
        end
        // Quiet line needs ten high bits after a low one
        apb(1, `IDX_SERIAL_CTRL, 32'h0000_0001);
        rxp <= 0;
        pulse(0, 1);
        rxp <= 1;
        pulse(0, 9);
        cmp_all();
        pulse(0, 1);
        ev[12] = 1;
        cmp_all();
        apb(1, `IDX_SERIAL_FLAGS, 32'h0000_0001);
        v = xs();
        kbd[v[2:0]] <= 0;
        repeat (2) @(posedge mclk);
        kbd <= 8'hff;
        ev[12] = 0;
        ev[14] = 1;
        cmp_all();
        apb(1, `IDX_KBD_CTRL, 32'h0000_0001);
        ev[14] = 0;
        apb(1, `IDX_CONV_CTRL, 32'h0000_0001);
        pulse(6, 1);
        ev[15] = 1;
        cmp_all();
        chk("complete", 0, ccb);
        pulse(7, 1);
        ev[15] = 0;
        apb(1, `IDX_CONV_CTRL, 32'h0000_0000);
        pulse(6, 1);
        @(negedge mclk);
        chk("complete", 1, ccb);
        // Timebase at rate 3 rolls over every 512 cycles; stale flag acked first
        apb(1, `IDX_TB_CTRL, 32'h0000_0003);
        apb(1, `IDX_TB_CTRL, 32'h0000_001b);
        tb_rise(t0);
        apb(1, `IDX_TB_CTRL, 32'h0000_001b);
        cmp_all();
        tb_rise(t1);
        chk("period", 512, (t1 - t0) / 50);
        apb(1, `IDX_TB_CTRL, 32'h0000_0010);
        apb(1, `IDX_NET_ENABLES, 32'h0000_07ff);
        txe <= 3'b010;
        ev[20] = 1;
        cmp_all();
        apb(1, `IDX_NET_ENABLES, 32'h0000_07fd);
        ev[20] = 0;
        pulse(8, 1);
        ev[19] = 1;
        slp <= 1;
        pulse(9, 1);
        ev[17] = 1;
        cmp_all();
        apb(1, `IDX_NET_FLAGS, 32'h0000_07f8);
        ev[17] = 0;
        ev[19] = 0;
        // One below and at the warning limit, at and one above the passive and bus-off limits, one enable at a time
        for (int k = 0; k < 5; k++)
        begin
            apb(1, `IDX_NET_ENABLES, 32'h1 << (`NET_RWRN + k));
            lim = k < 2 ? 96 : (k < 4 ? 128 : 256);
            for (int s = 0; s < 2; s++)
            begin
                if (k == 0 || k == 2)
                    rxc <= lim - 1 + s;
                else
                    txc <= lim - 1 + s;
                // Latched flag needs one edge before the request register sees it
                @(posedge mclk);
                ev[18] = s;
                cmp_all();
            end
            rxc <= 0;
            txc <= 0;
            apb(1, `IDX_NET_FLAGS, 32'h0000_07f8);
        end
        apb(1, `IDX_NET_ENABLES, 32'h1 << `NET_OVR);
        fgv <= 1;
        bgv <= 1;
        pulse(10, 1);
        cmp_all();
        results();
    end
    // Watchdog: the sequence needs well under ten thousand cycles
    initial
    begin
        #(50 * 10000);
        err_count++;
        results();
    end
endmodule : interrupt_source_flags_tb
`default_nettype wire
